/* File: rtl/loiex_exec.v */
/*
 * Single-cycle executor for no-operation, complement and the three OR
 * forms of an 8-bit core. Holds the working register and zero flag.
 * Assumes the core presents one opcode per cycle with a valid strobe, reads
 * the file register array combinationally at the address given, and accepts
 * a one-cycle write strobe with address and data.
 */
`timescale 1ns/100ps
`include "loiex_map.vh"

module loiex_exec (
    // Clock and reset.
    input wire clock,
    input wire rst_b,
    // Instruction in.
    input wire [11:0] opcode,
    input wire opcode_valid,
    // File register array read port.
    output wire [4:0] file_register_operand_addr,
    input wire [7:0] file_register_operand,
    // File register array write port.
    output reg file_wr_en,
    output reg [4:0] file_wr_addr,
    output reg [7:0] file_wr_data,
    // Architectural state.
    output wire [7:0] w_value,
    output wire zero_flag,
    // Decode status.
    output wire claimed,
    output reg done
);

    // Operation classes of the decoded opcode.
    localparam OPC_NONE = 3'h0;
    localparam OPC_NOP = 3'h1;
    localparam OPC_NOT = 3'h2;
    localparam OPC_OR_FW = 3'h3;
    localparam OPC_OR_WF = 3'h4;
    localparam OPC_OR_LIT = 3'h5;

    reg [7:0] w_reg;
    reg [7:0] w_next;
    reg z_reg;
    reg z_next;
    reg [2:0] op_class;
    reg [7:0] operand_a;
    reg [7:0] operand_b;
    reg [7:0] result;
    reg do_logic;
    reg to_file;
    reg wr_en_next;
    reg [4:0] wr_addr_next;
    reg [7:0] wr_data_next;
    reg done_next;
    wire res_zero;
    wire dec_nop;
    wire dec_not;
    wire dec_or_fw;
    wire dec_or_wf;
    wire dec_or_lit;
    wire [4:0] faddr;
    wire [7:0] lit_value;

    // ****************************************************************
    // Decode.
    // ****************************************************************
    assign dec_nop = (opcode & `LOIEX_MASK_FULL) == `LOIEX_OP_NOP;
    assign dec_not = (opcode & `LOIEX_MASK_FREG) == `LOIEX_OP_NOT;
    assign dec_or_fw = (opcode & `LOIEX_MASK_FREG) == `LOIEX_OP_OR_FW;
    assign dec_or_wf = (opcode & `LOIEX_MASK_FREG) == `LOIEX_OP_OR_WF;
    assign dec_or_lit = (opcode & `LOIEX_MASK_LIT) == `LOIEX_OP_OR_LIT;
    assign faddr = opcode[`LOIEX_FADDR_MSB:0];
    assign lit_value = opcode[`LOIEX_LIT_MSB:0];

    // The five encodings cannot overlap, so the order of tests is free.
    always @* begin
        op_class = OPC_NONE;
        if (opcode_valid) begin
            if (dec_nop) begin
                op_class = OPC_NOP;
            end else if (dec_not) begin
                op_class = OPC_NOT;
            end else if (dec_or_fw) begin
                op_class = OPC_OR_FW;
            end else if (dec_or_wf) begin
                op_class = OPC_OR_WF;
            end else if (dec_or_lit) begin
                op_class = OPC_OR_LIT;
            end
        end
    end

    assign file_register_operand_addr = faddr;
    // Only the five listed encodings are ours; nothing is rejected.
    assign claimed = (op_class != OPC_NONE);
    assign w_value = w_reg;
    assign zero_flag = z_reg;

    // ****************************************************************
    // Operand selection.
    // ****************************************************************
    always @* begin
        operand_a = `LOIEX_ZERO;
        operand_b = `LOIEX_ZERO;
        case (op_class)
            OPC_NOT: begin
                operand_a = file_register_operand;
                operand_b = `LOIEX_ALL_ONES;
            end
            OPC_OR_FW: begin
                operand_a = file_register_operand;
                operand_b = w_reg;
            end
            OPC_OR_WF: begin
                operand_a = w_reg;
                operand_b = file_register_operand;
            end
            OPC_OR_LIT: begin
                operand_a = w_reg;
                operand_b = lit_value;
            end
            default: begin
                operand_a = `LOIEX_ZERO;
                operand_b = `LOIEX_ZERO;
            end
        endcase
    end

    // ****************************************************************
    // Execute.
    // ****************************************************************
    always @* begin
        result = `LOIEX_ZERO;
        do_logic = 1'h0;
        to_file = 1'h0;
        case (op_class)
            OPC_NOT: begin
                result = operand_a ^ operand_b;
                do_logic = 1'h1;
                to_file = 1'h1;
            end
            OPC_OR_FW: begin
                result = operand_a | operand_b;
                do_logic = 1'h1;
                to_file = 1'h1;
            end
            OPC_OR_WF: begin
                result = operand_a | operand_b;
                do_logic = 1'h1;
            end
            OPC_OR_LIT: begin
                result = operand_a | operand_b;
                do_logic = 1'h1;
            end
            default: begin
                // No-operation and foreign opcodes leave all state alone.
                result = `LOIEX_ZERO;
                do_logic = 1'h0;
                to_file = 1'h0;
            end
        endcase
    end

    loiex_zero_detect u_zero (
        .value(result),
        .is_zero(res_zero)
    );

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always @* begin
        w_next = w_reg;
        z_next = z_reg;
        if (do_logic) begin
            z_next = res_zero;
            if (!to_file) begin
                w_next = result;
            end
        end
    end

    always @* begin
        wr_en_next = do_logic & to_file;
        wr_addr_next = faddr;
        wr_data_next = result;
        done_next = claimed;
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    always @(posedge clock) begin
        if (!rst_b) begin
            w_reg <= `LOIEX_W_RESET;
            z_reg <= `LOIEX_Z_RESET;
        end else begin
            w_reg <= w_next;
            z_reg <= z_next;
        end
    end

    // The write port is registered so the array sees one clean strobe.
    always @(posedge clock) begin
        if (!rst_b) begin
            file_wr_en <= 1'h0;
            file_wr_addr <= `LOIEX_FADDR_RESET;
            file_wr_data <= `LOIEX_ZERO;
        end else begin
            file_wr_en <= wr_en_next;
            file_wr_addr <= wr_addr_next;
            file_wr_data <= wr_data_next;
        end
    end

    always @(posedge clock) begin
        if (!rst_b) begin
            done <= 1'h0;
        end else begin
            done <= done_next;
        end
    end

endmodule

/* File: rtl/loiex_map.vh */
/*
 * Opcode patterns, field positions and reset values for the logic-group
 * instruction executor.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef LOIEX_MAP_VH
`define LOIEX_MAP_VH

// ****************************************************************
// Opcode patterns and masks.
// ****************************************************************
`define LOIEX_OP_NOP 12'h000
`define LOIEX_MASK_FULL 12'hFFF
`define LOIEX_OP_NOT 12'h260
`define LOIEX_OP_OR_FW 12'h120
`define LOIEX_OP_OR_WF 12'h100
`define LOIEX_MASK_FREG 12'hFE0
`define LOIEX_OP_OR_LIT 12'hD00
`define LOIEX_MASK_LIT 12'hF00

// ****************************************************************
// Field positions.
// ****************************************************************
`define LOIEX_FADDR_MSB 4
`define LOIEX_LIT_MSB 7

// ****************************************************************
// Reset values and constants.
// ****************************************************************
`define LOIEX_W_RESET 8'h00
`define LOIEX_Z_RESET 1'h0
`define LOIEX_FADDR_RESET 5'h00
`define LOIEX_ALL_ONES 8'hFF
`define LOIEX_ZERO 8'h00

`endif

/* File: rtl/loiex_zero_detect.v */
/*
 * Zero detector for an 8-bit result.
 * Assumes a purely combinational use inside the executor.
 */
`timescale 1ns/100ps
`include "loiex_map.vh"

module loiex_zero_detect (
    // Operand.
    input wire [7:0] value,
    // Result.
    output wire is_zero
);

    assign is_zero = (value == `LOIEX_ZERO);

endmodule

/* File: verif/logic_op_instruction_exec_tb_top.sv */
/* Self-checking bench for the logic-group executor.
   Assumes the bench holds the file array and forwards a pending write. */
`timescale 1ns/100ps
module logic_op_instruction_exec_tb_top;
    reg clock = 0, rst_b = 0, opcode_valid = 0, ez, ed, ewr, k;
    reg [11:0] opcode = 12'h000, op;
    reg [7:0] mem [0:31], emem [0:31], ew, t, ewd;
    reg [4:0] ewa;
    reg [31:0] rn;
    wire [4:0] ra, wa;
    wire [7:0] wd, w_value;
    wire wr, zero_flag, claimed, done;
    wire [7:0] rd = (wr && wa == ra) ? wd : mem[ra];
    integer fail_count = 0, checks_done = 0, cyc = 0, i;
    loiex_exec loiex_exec_inst (.clock, .rst_b, .opcode, .opcode_valid,
        .file_register_operand_addr(ra), .file_register_operand(rd),
        .file_wr_en(wr), .file_wr_addr(wa), .file_wr_data(wd), .w_value,
        .zero_flag, .claimed, .done);
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (wr)
            mem[wa] <= wd;
        if (cyc == 3000) begin
            fail_count = fail_count + 1;
            tally_and_finish;
        end
    end
    task chk8(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: byte %h not %h", $time, got, exp);
            end
        end
    endtask
    task chk1(input got, input exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: bit %b not %b", $time, got, exp);
            end
        end
    endtask
    task run(input [11:0] o, input vl);
        begin
            @(negedge clock);
            chk8(w_value, ew);
            chk1(zero_flag, ez);
            chk1(done, ed);
            chk1(wr, ewr);
            chk8(rd, emem[ra]);
            if (ewr) begin
                chk8(wd, ewd);
                chk8({3'h0, wa}, {3'h0, ewa});
            end
            opcode = o;
            opcode_valid = vl;
            t = emem[o[4:0]];
            k = vl;
            ewr = 0;
            if (vl)
                casez (o)
                    12'b0010011?????: begin
                        t = ~t;
                        emem[o[4:0]] = t;
                        ewr = 1;
                    end
                    12'b0001001?????: begin
                        t = t | ew;
                        emem[o[4:0]] = t;
                        ewr = 1;
                    end
                    12'b0001000?????: begin
                        t = t | ew;
                        ew = t;
                    end
                    12'b1101????????: begin
                        t = ew | o[7:0];
                        ew = t;
                    end
                    default: k = 0;
                endcase
            ed = k | (vl && o == 12'h000);
            ewa = o[4:0];
            ewd = t;
            if (k)
                ez = (t == 8'h00);
            #1 chk1(claimed, ed);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        rn = $urandom(32'h2c6e);
        for (i = 0; i < 32; i = i + 1) begin
            mem[i] = i == 0 ? 8'hFF : i == 1 ? 8'h00 : $urandom;
            emem[i] = mem[i];
        end
        {ew, ez, ed, ewr} = 11'h000;
        repeat (10) @(negedge clock);
        rst_b = 1;
        run(12'hD00, 1);
        run(12'h260, 1);
        run(12'h12A, 1);
        run(12'h000, 1);
        run(12'h12A, 1);
        for (i = 0; i < 600; i = i + 1) begin
            rn = $urandom;
            case (rn[14:12])
                0: op = 12'h000;
                1: op = {7'h13, rn[4:0]};
                2: op = {7'h09, rn[4:0]};
                3: op = {7'h08, rn[4:0]};
                4: op = {4'hD, rn[7:0] & rn[15:8]};
                default: op = rn[11:0];
            endcase
            run(op, rn[16] | rn[17]);
        end
        run(12'h000, 0);
        tally_and_finish;
    end
endmodule

/* File: verif/loiex_exec_chk.sv */
/* Port checker for the logic-group executor.
   Assumes binding onto loiex_exec; it sees only that module's ports. */
`timescale 1ns/100ps
module loiex_exec_chk (
    // Clock and reset.
    input wire clock,
    input wire rst_b,
    // Instruction in.
    input wire [11:0] opcode,
    input wire opcode_valid,
    // File register array.
    input wire [4:0] file_register_operand_addr,
    input wire [7:0] file_register_operand,
    input wire file_wr_en,
    input wire [4:0] file_wr_addr,
    input wire [7:0] file_wr_data,
    // Architectural state and status.
    input wire [7:0] w_value,
    input wire zero_flag,
    input wire claimed,
    input wire done
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire v = opcode_valid;
    wire [6:0] g = opcode[11:5];
    wire [7:0] f = file_register_operand;
    nop_quiet_a: assert property (
        v && opcode == 12'h000 |=> done && !file_wr_en
        && $stable(w_value) && $stable(zero_flag))
        else $error("nop changed state");
    not_write_a: assert property (
        v && g == 7'h13 |=> file_wr_en && file_wr_data == ~$past(f)
        && $stable(w_value)) else $error("complement wrong");
    zero_write_a: assert property (
        file_wr_en |-> zero_flag == (file_wr_data == 8'h00))
        else $error("zero flag wrong on write");
    or_file_a: assert property (
        v && g == 7'h09 |=> file_wr_en && $stable(w_value)
        && file_wr_data == ($past(f) | $past(w_value)))
        else $error("or into file wrong");
    or_work_a: assert property (
        v && g == 7'h08 |=> !file_wr_en
        && w_value == ($past(w_value) | $past(f))
        && zero_flag == (w_value == 8'h00)) else $error("or into w wrong");
    or_lit_a: assert property (
        v && opcode[11:8] == 4'hD |=> !file_wr_en
        && w_value == ($past(w_value) | $past(opcode[7:0]))
        && zero_flag == (w_value == 8'h00)) else $error("or literal wrong");
    addr_field_a: assert property (
        file_wr_en |-> file_wr_addr == $past(file_register_operand_addr))
        else $error("write address wrong");
    unclaimed_a: assert property (
        v && !claimed |=> !done && !file_wr_en && $stable(w_value)
        && $stable(zero_flag)) else $error("unclaimed opcode acted");
endmodule
bind loiex_exec loiex_exec_chk loiex_exec_chk_inst (.clock, .rst_b,
    .opcode_valid, .file_wr_en, .zero_flag, .claimed, .done, .opcode,
    .file_register_operand_addr, .file_wr_addr, .file_register_operand,
    .file_wr_data, .w_value);
